// [bench/digital_io_with_interrupts_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dioirq_params.svh"

module digital_io_with_interrupts_tb_top
	import dioirq_pkg::*;
;

	logic         clk = 1'b0;
	logic         nrst = 1'b0;
	logic         ce = 1'b1;
	logic         ext_drv = 1'b1;
	logic  [23:0] drv = '1;
	logic  [23:0] pins;
	logic  [23:0] out;
	logic  [23:0] oe;
	dioirq_req_s  req;
	dioirq_byte_t rdata;
	dioirq_byte_t rd_v;
	logic         irq;
	logic  [31:0] seed = 32'h0da09870;
	logic   [7:0] v, d, l, e, x, cfg, idl, lvl;
	logic   [1:0] mu, ml;
	int           err_total = 0;
	int           samples_checked = 0;

	// 10 MHz clock
	always #50 clk = ~clk;

	// open collector: pulled low while driven, else the far driver
	assign pins = ~oe & drv;

	dioirq_top uut (
		.clk(clk), .nrst(nrst), .ce(ce), .host_req(req),
		.host_rdata_ff(rdata), .host_irq_ff(irq),
		.io_channels_in(pins), .io_channels_out_ff(out),
		.io_channels_oe_ff(oe), .ext_irq_in(ext_drv)
	);

	dioirq_host_model host (.clk(clk), .req(req), .rdata(rdata));

	// xorshift, fixed seed for repeatable runs
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input logic [7:0] s, input logic [7:0] ex);
		samples_checked++;
		if (s !== ex) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, ex);
		end
	endtask

	task automatic rdc(input logic [2:0] a, input logic [7:0] ex);
		host.rd(a, rd_v);
		chk(rd_v, ex);
	endtask

	task automatic results();
		if (err_total == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		results();
	end

	initial begin
		repeat (20) @(posedge clk);
		#1;
		nrst = 1'b1;
		// reset values and an unmapped offset
		rdc(`DIO_OFS_PORT_B, 8'hff);
		rdc(`DIO_OFS_IRQ_EN, 8'h00);
		rdc(`DIO_OFS_TRIG, 8'h00);
		rdc(3'h3, 8'h00);
		rdc(`DIO_OFS_PEND, 8'h00);
		// latch, driver and masked read-back per port
		for (int p = 0; p < 3; p++) begin
			v = 8'(rnd());
			d = 8'(rnd());
			drv[p*8 +: 8] = d;
			host.wr(3'(p), v);
			@(posedge clk);
			#1;
			chk(oe[p*8 +: 8], ~v);
			chk(out[p*8 +: 8], 8'h00);
			rdc(3'(p), v & d);
		end
		// every mode in both nibbles, ext follows the upper one
		for (int m = 0; m < 4; m++) begin
			mu = m[1:0];
			ml = ~mu;
			l = 8'(rnd()) | 8'h01;
			e = 8'(rnd()) | 8'h01;
			idl = {{4{~mu[0]}}, {4{~ml[0]}}};
			lvl = {{4{~mu[1]}}, {4{~ml[1]}}};
			cfg = {2'b01, mu, mu, ml};
			drv[23:16] = idl;
			ext_drv = ~mu[0];
			host.wr(`DIO_OFS_PORT_C, l);
			host.wr(`DIO_OFS_IRQ_EN, e);
			host.wr(`DIO_OFS_TRIG, cfg);
			host.ack(8'hff);
			host.wr(`DIO_OFS_TRIG, cfg | 8'h80);
			rdc(`DIO_OFS_PEND, 8'h00);
			rdc(`DIO_OFS_TRIG, cfg);
			// all channels and ext go active together
			drv[23:16] = ~idl;
			ext_drv = mu[0];
			repeat (3) @(posedge clk);
			#1;
			x = e & l;
			rdc(`DIO_OFS_PEND, x);
			rdc(`DIO_OFS_PORT_C, l & ~idl);
			rdc(`DIO_OFS_TRIG, cfg | 8'h80);
			chk({7'h0, irq}, 8'h01);
			// ack while conditions live: only levels survive
			host.ack(8'hff);
			chk({7'h0, irq}, 8'h00);
			@(posedge clk);
			#1;
			chk({7'h0, irq}, 8'h01);
			rdc(`DIO_OFS_PEND, x & lvl);
			host.wr(`DIO_OFS_TRIG, cfg | 8'h80);
			rdc(`DIO_OFS_TRIG, cfg | {~mu[1], 7'h00});
			// conditions gone, then ack clears all
			drv[23:16] = idl;
			ext_drv = ~mu[0];
			host.ack(8'hff);
			host.wr(`DIO_OFS_TRIG, cfg | 8'h80);
			rdc(`DIO_OFS_PEND, 8'h00);
			rdc(`DIO_OFS_TRIG, cfg);
			chk({7'h0, irq}, 8'h00);
		end
		// ce low: writes must not land, registers stay frozen
		ce = 1'b0;
		host.wr(`DIO_OFS_IRQ_EN, 8'(rnd()));
		host.wr(`DIO_OFS_PORT_C, 8'h00);
		ce = 1'b1;
		rdc(`DIO_OFS_IRQ_EN, e);
		rdc(`DIO_OFS_PORT_C, l & idl);
		chk(oe[23:16], ~l);
		results();
	end

endmodule

`default_nettype wire

// [bench/dioirq_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dioirq_params.svh"

module dioirq_host_model
	import dioirq_pkg::*;
(
	// clock
	input  wire logic          clk,
	// host i/o cycle towards the card
	output var dioirq_req_s    req,
	input  wire dioirq_byte_t  rdata
);

	// idle bus, no strobe
	initial req = '0;

	// one write, held across one sampling edge
	task automatic wr(input logic [2:0] a, input dioirq_byte_t d);
		@(posedge clk);
		#1;
		req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		#1;
		// released lines show garbage, not the old value
		req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask

	// one read, data taken at the answering edge
	task automatic rd(input logic [2:0] a, output dioirq_byte_t d);
		@(posedge clk);
		#1;
		req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk);
		#1;
		d = rdata;
		req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
	endtask

	task automatic ack(input dioirq_byte_t m);
		wr(`DIO_OFS_PEND, m);
	endtask

endmodule

`default_nettype wire

// [common/dioirq_params.svh]
`ifndef DIOIRQ_PARAMS_SVH
`define DIOIRQ_PARAMS_SVH

// register offsets within the eight-byte window
`define DIO_OFS_PORT_A   3'h0
`define DIO_OFS_PORT_B   3'h1
`define DIO_OFS_PORT_C   3'h2
`define DIO_OFS_IRQ_EN   3'h5
`define DIO_OFS_TRIG     3'h6
`define DIO_OFS_PEND     3'h7
`define DIO_OFS_HOLE_LO  3'h3
`define DIO_OFS_HOLE_HI  3'h4

// reset values
`define DIO_LATCH_RST    8'hff
`define DIO_IEN_RST      8'h00
`define DIO_CFG_RST      7'h00
`define DIO_ZERO8        8'h00
`define DIO_ZERO24       24'h000000
`define DIO_PIN_IDLE     1'b1

// trigger config register fields
`define DIO_BIT_EXT_ACK  7
`define DIO_BIT_EXT_EN   6
`define DIO_FLD_EXT_MODE 5:4
`define DIO_FLD_UP_MODE  3:2
`define DIO_FLD_LO_MODE  1:0
`define DIO_FLD_CFG      6:0

// first source served by the upper mode field
`define DIO_UPPER_FIRST  4

// number of channel sources and the first channel they watch
`define DIO_NSRC         8
`define DIO_CHAN_C_FIRST 16

`endif

// [common/dioirq_pkg.sv]
package dioirq_pkg;

	// one register byte
	typedef logic [7:0] dioirq_byte_t;

	// trigger modes of a source
	typedef enum logic [1:0] {
		TRIG_LVL_LOW  = 2'b00,
		TRIG_LVL_HIGH = 2'b01,
		TRIG_FALL     = 2'b10,
		TRIG_RISE     = 2'b11
	} dioirq_trig_e;

	// one host i/o cycle, sampled in a single clock
	typedef struct packed {
		logic         wr;
		logic         rd;
		logic [2:0]   addr;
		dioirq_byte_t wdata;
	} dioirq_req_s;

endpackage

// [design/dioirq_src.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dioirq_params.svh"

module dioirq_src
	import dioirq_pkg::*;
(
	// clock, reset, enable
	input  wire logic   clk,
	input  wire logic   nrst,
	input  wire logic   ce,
	// source and control
	input  wire logic   pin,
	input  wire logic   arm,
	input  wire dioirq_trig_e mode,
	input  wire logic   ack,
	// pending flag
	output logic        pend_ff
);

	logic prev_ff;
	logic cond;
	logic hit;

	// previous pin level; starts at the pulled-up idle level
	// so a quiet pin shows no false edge after reset
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prev_ff <= `DIO_PIN_IDLE;
		end else if (ce) begin
			prev_ff <= pin;
		end
	end

	always_comb begin
		unique case (mode)
			TRIG_LVL_LOW:  cond = !pin;
			TRIG_LVL_HIGH: cond = pin;
			TRIG_FALL:     cond = prev_ff && !pin;
			TRIG_RISE:     cond = !prev_ff && pin;
		endcase
	end

	// a disarmed source never counts as a live condition
	assign hit = arm && cond;

	// set wins over ack; clear needs ack and no condition
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pend_ff <= 1'b0;
		end else if (ce) begin
			if (hit) begin
				pend_ff <= 1'b1;
			end else if (ack) begin
				pend_ff <= 1'b0;
			end
		end
	end

	property p_src_set;
		@(posedge clk) disable iff (!nrst)
		ce && hit |=> pend_ff;
	endproperty
	a_src_set: assert property (p_src_set)
		else $error("live condition did not set pending flag");

	property p_src_clear;
		@(posedge clk) disable iff (!nrst)
		ce && ack && !hit |=> !pend_ff;
	endproperty
	a_src_clear: assert property (p_src_clear)
		else $error("ack without condition did not clear flag");

endmodule
`default_nettype wire

// [design/dioirq_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dioirq_params.svh"

// Summary of operation
// - source fires only if input and enabled
// - eight sources map onto channels 16 to 23
// - low, high, falling and rising trigger modes
// - separate modes for upper and lower nibble
// - firing source sets its pending bit
// - pending bits accumulate without waiting
// - after ack write, irq again if pending
// - bit clears on ack when condition gone
// - live level after ack fires again
// - one extra external interrupt input
// - offset 6 controls the external interrupt
// - external input behaves like a channel source
// - eight byte map, status and ack at 7
// - first latch covers channels 0 to 7
// - second latch covers channels 8 to 15
// - third latch covers channels 16 to 23
// - latch one makes channel a readable input
// - enable bit n arms source n
// - armed channel still reads as data
// - two-bit mode codes and field positions
// - bit 7 ext status/ack, bit 6 enable
// - latch zero drives low, reads zero
// - reset loads all latches with ones

module dioirq_top
	import dioirq_pkg::*;
#(
	parameter int unsigned NPORTS = 3
)(
	// clock, reset, enable
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic         ce,
	// host i/o cycle
	input  wire dioirq_req_s  host_req,
	output dioirq_byte_t      host_rdata_ff,
	output logic              host_irq_ff,
	// open-collector channels
	input  wire logic [23:0]  io_channels_in,
	output logic      [23:0]  io_channels_out_ff,
	output logic      [23:0]  io_channels_oe_ff,
	// external interrupt pin
	input  wire logic         ext_irq_in
);

	dioirq_byte_t port_latch_ff [NPORTS];
	dioirq_byte_t ien_ff;
	logic [6:0]   cfg_ff;
	logic [7:0]   chan_pend;
	logic         ext_irq_pending;
	logic [7:0]   chan_arm;
	logic [7:0]   chan_ack;
	logic         ext_irq_clear;
	logic         ack_wr;
	logic         any_pend;
	logic [23:0]  latch_flat;
	logic [23:0]  masked_in;
	dioirq_byte_t nxt_rdata;
	logic         nxt_irq;
	dioirq_trig_e upper_nibble_trigger_mode;
	dioirq_trig_e lower_nibble_trigger_mode;
	dioirq_trig_e ext_irq_trigger_mode;

	// write decode, shared by every register except the port latches
	function automatic logic wr_hit(input dioirq_req_s r,
			input logic [2:0] ofs);
		return r.wr && (r.addr == ofs);
	endfunction

	// read decode, used by the checks only, not by the mux
	function automatic logic rd_hit(input dioirq_req_s r,
			input logic [2:0] ofs);
		return r.rd && (r.addr == ofs);
	endfunction

	// flat view of the three latches
	assign latch_flat = {port_latch_ff[2], port_latch_ff[1],
			port_latch_ff[0]};

	// channels latched low are masked on read
	assign masked_in = io_channels_in & latch_flat;

	// latch writes, one byte per port
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int p = 0; p < NPORTS; p++) begin
				port_latch_ff[p] <= `DIO_LATCH_RST;
			end
		end else if (ce && host_req.wr &&
				host_req.addr <= `DIO_OFS_PORT_C) begin
			port_latch_ff[host_req.addr[1:0]] <= host_req.wdata;
		end
	end

	// zero in the latch turns the driver on
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			io_channels_oe_ff <= `DIO_ZERO24;
		end else if (ce) begin
			io_channels_oe_ff <= ~latch_flat;
		end
	end

	// open collector only ever pulls low, so no driven high
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			io_channels_out_ff <= `DIO_ZERO24;
		end else if (ce) begin
			io_channels_out_ff <= `DIO_ZERO24;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ien_ff <= `DIO_IEN_RST;
		end else if (ce && wr_hit(host_req, `DIO_OFS_IRQ_EN)) begin
			ien_ff <= host_req.wdata;
		end
	end

	// trigger config; the ack bit is not stored
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cfg_ff <= `DIO_CFG_RST;
		end else if (ce && wr_hit(host_req, `DIO_OFS_TRIG)) begin
			cfg_ff <= host_req.wdata[`DIO_FLD_CFG];
		end
	end

	// mode fields of the config register
	assign upper_nibble_trigger_mode =
			dioirq_trig_e'(cfg_ff[`DIO_FLD_UP_MODE]);
	assign lower_nibble_trigger_mode =
			dioirq_trig_e'(cfg_ff[`DIO_FLD_LO_MODE]);
	assign ext_irq_trigger_mode =
			dioirq_trig_e'(cfg_ff[`DIO_FLD_EXT_MODE]);

	// armed only when input and enabled
	assign chan_arm = ien_ff & port_latch_ff[2];

	// ack strobes, valid only in the write cycle
	assign chan_ack = wr_hit(host_req, `DIO_OFS_PEND) ?
			host_req.wdata : `DIO_ZERO8;

	// bit 7 written as one acks the external source
	assign ext_irq_clear = wr_hit(host_req, `DIO_OFS_TRIG) &&
			host_req.wdata[`DIO_BIT_EXT_ACK];

	assign ack_wr = wr_hit(host_req, `DIO_OFS_PEND) || ext_irq_clear;
	assign any_pend = (|chan_pend) || ext_irq_pending;

	for (genvar n = 0; n < `DIO_NSRC; n++) begin : g_src
		dioirq_src u_src (
			.clk     (clk),
			.nrst    (nrst),
			.ce      (ce),
			.pin     (io_channels_in[`DIO_CHAN_C_FIRST + n]),
			.arm     (chan_arm[n]),
			.mode    ((n >= `DIO_UPPER_FIRST) ?
					upper_nibble_trigger_mode :
					lower_nibble_trigger_mode),
			.ack     (chan_ack[n]),
			// each flag sets on its own
			.pend_ff (chan_pend[n])
		);
	end

	// external source, same logic as a channel
	dioirq_src u_ext_src (
		.clk     (clk),
		.nrst    (nrst),
		.ce      (ce),
		.pin     (ext_irq_in),
		.arm     (cfg_ff[`DIO_BIT_EXT_EN]),
		.mode    (ext_irq_trigger_mode),
		.ack     (ext_irq_clear),
		.pend_ff (ext_irq_pending)
	);

	// read mux; holes read as zero
	always_comb begin
		nxt_rdata = `DIO_ZERO8;
		unique case (host_req.addr)
			// inputs read through the latch mask
			`DIO_OFS_PORT_A: nxt_rdata = masked_in[7:0];
			`DIO_OFS_PORT_B: nxt_rdata = masked_in[15:8];
			`DIO_OFS_PORT_C: nxt_rdata = masked_in[23:16];
			`DIO_OFS_IRQ_EN: nxt_rdata = ien_ff;
			// status in bit 7 above the config
			`DIO_OFS_TRIG:   nxt_rdata = {ext_irq_pending, cfg_ff};
			// pending flags, bit n is source n
			`DIO_OFS_PEND:   nxt_rdata = chan_pend;
			default:         nxt_rdata = `DIO_ZERO8;
		endcase
	end

	// read data stands until the next read
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			host_rdata_ff <= `DIO_ZERO8;
		end else if (ce && host_req.rd) begin
			host_rdata_ff <= nxt_rdata;
		end
	end

	// dip for one cycle on ack so the host sees
	// a fresh edge whenever flags remain
	assign nxt_irq = any_pend && !ack_wr;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			host_irq_ff <= 1'b0;
		end else if (ce) begin
			host_irq_ff <= nxt_irq;
		end
	end

	// ack write accepted in an enabled cycle
	sequence s_ack_wr;
		ce && ack_wr;
	endsequence

	// ordinary cycle with no ack
	sequence s_no_ack;
		ce && !ack_wr;
	endsequence

	property p_irq_dip;
		@(posedge clk) disable iff (!nrst)
		s_ack_wr |=> !host_irq_ff;
	endproperty
	a_irq_dip: assert property (p_irq_dip)
		else $error("irq did not dip after ack write");

	property p_irq_follow;
		@(posedge clk) disable iff (!nrst)
		s_no_ack |=> host_irq_ff == $past(any_pend);
	endproperty
	a_irq_follow: assert property (p_irq_follow)
		else $error("irq does not follow pending flags");

	property p_irq_reraise;
		@(posedge clk) disable iff (!nrst)
		s_ack_wr ##1 (s_no_ack and any_pend) |=> host_irq_ff;
	endproperty
	a_irq_reraise: assert property (p_irq_reraise)
		else $error("irq not raised again after ack");

	property p_no_set_disarmed;
		@(posedge clk) disable iff (!nrst)
		ce |=> (chan_pend & ~$past(chan_pend) & ~$past(chan_arm))
				== `DIO_ZERO8;
	endproperty
	a_no_set_disarmed: assert property (p_no_set_disarmed)
		else $error("disarmed source set its flag");

	property p_oe_port_a;
		@(posedge clk) disable iff (!nrst)
		ce && wr_hit(host_req, `DIO_OFS_PORT_A) ##1 ce
				|=> io_channels_oe_ff[7:0] == ~$past(host_req.wdata, 2);
	endproperty
	a_oe_port_a: assert property (p_oe_port_a)
		else $error("port a drivers do not follow latch");

	property p_oe_port_c;
		@(posedge clk) disable iff (!nrst)
		ce && wr_hit(host_req, `DIO_OFS_PORT_C) ##1 ce
				|=> io_channels_oe_ff[23:16] == ~$past(host_req.wdata, 2);
	endproperty
	a_oe_port_c: assert property (p_oe_port_c)
		else $error("port c drivers do not follow latch");

	property p_read_port_b;
		@(posedge clk) disable iff (!nrst)
		ce && rd_hit(host_req, `DIO_OFS_PORT_B)
				|=> host_rdata_ff == $past(masked_in[15:8]);
	endproperty
	a_read_port_b: assert property (p_read_port_b)
		else $error("port b read not masked by latch");

	property p_read_ext_stat;
		@(posedge clk) disable iff (!nrst)
		ce && rd_hit(host_req, `DIO_OFS_TRIG)
				|=> host_rdata_ff[`DIO_BIT_EXT_ACK] == $past(ext_irq_pending);
	endproperty
	a_read_ext_stat: assert property (p_read_ext_stat)
		else $error("bit 7 does not show external status");

	property p_read_pend;
		@(posedge clk) disable iff (!nrst)
		ce && rd_hit(host_req, `DIO_OFS_PEND)
				|=> host_rdata_ff == $past(chan_pend);
	endproperty
	a_read_pend: assert property (p_read_pend)
		else $error("status read does not show flags");

	property p_read_hole;
		@(posedge clk) disable iff (!nrst)
		ce && host_req.rd && (host_req.addr == `DIO_OFS_HOLE_LO ||
				host_req.addr == `DIO_OFS_HOLE_HI)
				|=> host_rdata_ff == `DIO_ZERO8;
	endproperty
	a_read_hole: assert property (p_read_hole)
		else $error("unmapped offset read not zero");

endmodule
`default_nettype wire
